//--- common/dsp_pkg.sv
package dsp_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] DSP_ADDR_STACK_POINTER = 8'h81;
   localparam logic [7:0] DSP_ADDR_DP_LOW        = 8'h82;
   localparam logic [7:0] DSP_ADDR_DP_HIGH       = 8'h83;
   localparam logic [7:0] DSP_RST_STACK_POINTER  = 8'h07;
   localparam logic [7:0] DSP_RST_DP_LOW         = 8'h00;
   localparam logic [7:0] DSP_RST_DP_HIGH        = 8'h00;
   localparam logic [7:0] DSP_RESERVED_READ      = 8'h00;
   localparam logic [7:0] DSP_STACK_STEP         = 8'h01;
   localparam logic [7:0] DSP_SFR_BASE           = 8'h80;
   localparam int         DSP_STACK_DEPTH        = 256;

   // ------------------------------------------------------------
   // Stack operation state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      DSP_IDLE = 2'b00,
      DSP_PUSH = 2'b01,
      DSP_POP  = 2'b10
   } dsp_state_t;
endpackage

//--- common/dsp_mem_if.sv
`timescale 1ns/1ps
interface dsp_mem_if;
   logic       wrEn;
   logic [7:0] addr;
   logic [7:0] wrData;
   logic [7:0] rdData;
   modport ctrl (output wrEn, output addr, output wrData, input rdData);
   modport mem  (input wrEn, input addr, input wrData, output rdData);
endinterface

//--- hdl/dsp_stack_ram.sv
`timescale 1ns/1ps
module dsp_stack_ram
   import dsp_pkg::*;
(
   input wire logic sys_clk,
   dsp_mem_if.mem   port
);
   // ------------------------------------------------------------
   // Stack memory with registered read data.
   // ------------------------------------------------------------
   logic [7:0] memQ [DSP_STACK_DEPTH];
   logic [7:0] rdQ;

   always_ff @(posedge sys_clk) begin
      if (port.wrEn) begin
         memQ[port.addr] <= port.wrData;
      end
      rdQ <= memQ[port.addr];
   end

   assign port.rdData = rdQ;
endmodule

//--- hdl/dsp_pointer_regs.sv
`timescale 1ns/1ps
// Functional notes
// - Low data pointer byte holds bits 7..0.
// - High byte holds bits 15..8, concatenated.
// - Combined pointer addresses Flash and external RAM.
// - Stack pointer holds current stack top.
// - Push increments pointer, then writes byte.
// - Stack pointer resets to 0x07.
// - Unassigned register addresses are reserved.
// - Pointer marks last written location.
// - Stack may use all 256 bytes.
module dsp_pointer_regs
   import dsp_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        sfrWrEn,
   input  wire logic        sfrRdEn,
   input  wire logic [7:0]  sfrAddr,
   input  wire logic [7:0]  sfrWrData,
   output logic      [7:0]  sfrRdData,
   output logic             sfrHit,
   input  wire logic        pushReq,
   input  wire logic [7:0]  pushData,
   input  wire logic        popReq,
   output logic      [7:0]  popData,
   output logic             popValid,
   output logic             stackBusy,
   output logic      [15:0] dataPointer,
   output logic      [7:0]  stackPointer
);
   // ------------------------------------------------------------
   // Pointer and stack state.
   // ------------------------------------------------------------
   logic [7:0] spQ;
   logic [7:0] spD;
   logic [7:0] dplQ;
   logic [7:0] dplD;
   logic [7:0] dphQ;
   logic [7:0] dphD;
   logic [7:0] pushQ;
   logic [7:0] pushD;
   dsp_state_t stQ;
   dsp_state_t stD;

   // ------------------------------------------------------------
   // Read-back and status state.
   // ------------------------------------------------------------
   logic [7:0] rdQ;
   logic [7:0] rdD;
   logic       hitQ;
   logic       hitD;
   logic       popVQ;
   logic       popVD;
   logic       busyQ;
   logic       busyD;

   // ------------------------------------------------------------
   // Address decode.
   // ------------------------------------------------------------
   logic       selSp;
   logic       selDpl;
   logic       selDph;
   logic       selAny;

   assign selSp  = (sfrAddr == DSP_ADDR_STACK_POINTER);
   assign selDpl = (sfrAddr == DSP_ADDR_DP_LOW);
   assign selDph = (sfrAddr == DSP_ADDR_DP_HIGH);
   assign selAny = selSp || selDpl || selDph;

   // ------------------------------------------------------------
   // Stack memory.
   // ------------------------------------------------------------
   dsp_mem_if  mem ();

   dsp_stack_ram dsp_stack_ram_inst (
      .sys_clk (sys_clk),
      .port    (mem.mem)
   );

   // The write lands one cycle after the pointer has moved up.
   always_comb begin
      mem.wrEn   = (stQ == DSP_PUSH);
      mem.addr   = spQ;
      mem.wrData = pushQ;
   end

   // ------------------------------------------------------------
   // Pointer and stack next state.
   // ------------------------------------------------------------
   always_comb begin
      spD   = spQ;
      dplD  = dplQ;
      dphD  = dphQ;
      pushD = pushQ;
      stD   = stQ;
      if (sfrWrEn) begin
         if (selSp) begin
            spD = sfrWrData;
         end
         if (selDpl) begin
            dplD = sfrWrData;
         end
         if (selDph) begin
            dphD = sfrWrData;
         end
      end
      // A push request, or the pop decrement a cycle after the request, overrides a stack pointer write in the same cycle.
      case (stQ)
         DSP_IDLE: begin
            if (pushReq) begin
               spD   = spQ + DSP_STACK_STEP;
               pushD = pushData;
               stD   = DSP_PUSH;
            end else if (popReq) begin
               stD = DSP_POP;
            end
         end
         DSP_PUSH: begin
            stD = DSP_IDLE;
         end
         DSP_POP: begin
            spD = spQ - DSP_STACK_STEP;
            stD = DSP_IDLE;
         end
         default: begin
            stD = DSP_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Pointer and stack registers.
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         spQ   <= DSP_RST_STACK_POINTER;
         dplQ  <= DSP_RST_DP_LOW;
         dphQ  <= DSP_RST_DP_HIGH;
         pushQ <= 8'h00;
         stQ   <= DSP_IDLE;
      end else begin
         spQ   <= spD;
         dplQ  <= dplD;
         dphQ  <= dphD;
         pushQ <= pushD;
         stQ   <= stD;
      end
   end

   // ------------------------------------------------------------
   // Read-back next state.
   // ------------------------------------------------------------
   always_comb begin
      rdD  = DSP_RESERVED_READ;
      hitD = 1'b0;
      if (sfrRdEn && selAny) begin
         hitD = 1'b1;
         case (sfrAddr)
            DSP_ADDR_STACK_POINTER: begin
               rdD = spQ;
            end
            DSP_ADDR_DP_LOW: begin
               rdD = dplQ;
            end
            DSP_ADDR_DP_HIGH: begin
               rdD = dphQ;
            end
            default: begin
               rdD = DSP_RESERVED_READ;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Read-back registers.
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdQ  <= DSP_RESERVED_READ;
         hitQ <= 1'b0;
      end else begin
         rdQ  <= rdD;
         hitQ <= hitD;
      end
   end

   // ------------------------------------------------------------
   // Status next state.
   // ------------------------------------------------------------
   always_comb begin
      popVD = (stQ == DSP_POP);
      busyD = (stD != DSP_IDLE);
   end

   // ------------------------------------------------------------
   // Status registers.
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         popVQ <= 1'b0;
         busyQ <= 1'b0;
      end else begin
         popVQ <= popVD;
         busyQ <= busyD;
      end
   end

   // ------------------------------------------------------------
   // Outputs.
   // ------------------------------------------------------------
   assign sfrRdData    = rdQ;
   assign sfrHit       = hitQ;
   assign popData      = mem.rdData;
   assign popValid     = popVQ;
   assign stackBusy    = busyQ;
   assign dataPointer  = {dphQ, dplQ};
   assign stackPointer = spQ;
endmodule

//--- test/dsp_pointer_regs_assertions.sv
`timescale 1ns/1ps
module dsp_pointer_regs_assertions (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        sfrWrEn,
   input wire logic        sfrRdEn,
   input wire logic        pushReq,
   input wire logic        popReq,
   input wire logic        stackBusy,
   input wire logic        sfrHit,
   input wire logic        popValid,
   input wire logic [7:0]  sfrAddr,
   input wire logic [7:0]  sfrWrData,
   input wire logic [7:0]  sfrRdData,
   input wire logic [7:0]  stackPointer,
   input wire logic [15:0] dataPointer
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence popGo; popReq && !pushReq && !stackBusy; endsequence
   sequence pushGo; pushReq && !stackBusy; endsequence
   AST_SR: assert property ($past(rst) |-> stackPointer == 8'h07) else $error("sp");
   AST_DL: assert property (sfrWrEn && sfrAddr == 8'h82 |=>
      dataPointer[7:0] == $past(sfrWrData)) else $error("dl");
   AST_DH: assert property (sfrWrEn && sfrAddr == 8'h83 |=>
      dataPointer[15:8] == $past(sfrWrData)) else $error("dh");
   AST_PU: assert property (pushGo |=> stackBusy &&
      stackPointer == $past(stackPointer) + 8'h01) else $error("pu");
   AST_PO: assert property (popGo |-> ##2
      stackPointer == $past(stackPointer, 2) - 8'h01) else $error("po");
   AST_SW: assert property (sfrWrEn && sfrAddr == 8'h81 && !pushReq && !popReq &&
      !stackBusy |=> stackPointer == $past(sfrWrData)) else $error("sw");
   AST_RD: assert property (sfrRdEn && sfrAddr == 8'h81 |=>
      sfrRdData == $past(stackPointer)) else $error("rd");
   AST_RV: assert property (sfrRdEn && (sfrAddr < 8'h81 || sfrAddr > 8'h83) |=>
      sfrRdData == 8'h00 && !sfrHit) else $error("rv");
   AST_HT: assert property (sfrRdEn && sfrAddr >= 8'h81 && sfrAddr <= 8'h83 |=>
      sfrHit) else $error("ht");
   AST_PV: assert property (popGo |-> ##2 popValid) else $error("pv");
   AST_BZ: assert property (stackBusy |=> !stackBusy) else $error("bz");
endmodule
bind dsp_pointer_regs dsp_pointer_regs_assertions chk (.*);

//--- test/dsp_core_model.sv
`timescale 1ns/1ps
module dsp_core_model (
   input wire logic       sys_clk,
   input wire logic       popValid,
   input wire logic [7:0] popData,
   output logic           pushReq,
   output logic           popReq,
   output logic     [7:0] pushData
);
   initial {pushReq, popReq, pushData} = 10'h000;
   task automatic op(input logic pu, input logic [7:0] d, output logic [7:0] q);
      {pushReq, popReq, pushData} = {pu, !pu, d};
      @(posedge sys_clk) #1 {pushReq, popReq, pushData} = {2'b00, ~d};
      @(posedge sys_clk) #1 q = popValid ? popData : 8'hxx;
   endtask
endmodule

//--- test/dsp_pointer_regs_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failCount++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module dsp_pointer_regs_bench;
   logic        sys_clk = 1'b0, rst = 1'b1, sfrWrEn = 1'b0, sfrRdEn = 1'b0;
   logic        pushReq, popReq, sfrHit, popValid, stackBusy, hit;
   logic [7:0]  sfrAddr = 8'h00, sfrWrData = 8'h00, got;
   logic [7:0]  sfrRdData, pushData, popData, stackPointer;
   logic [15:0] dataPointer;
   int          failCount = 0, checks = 0;
   dsp_pointer_regs dsp_pointer_regs_inst (.*);
   dsp_core_model core (.*);
   initial forever #25 sys_clk = ~sys_clk;
   task automatic special_function_register(input logic w, input logic [7:0] a, d);
      {sfrWrEn, sfrRdEn, sfrAddr, sfrWrData} = {w, !w, a, d};
      @(posedge sys_clk) #1 {sfrWrEn, sfrRdEn} = 2'b00;
      got = sfrRdData;
      hit = sfrHit;
      @(posedge sys_clk) #1;
   endtask
   task automatic printVerdict();
      $display("checks %0d mismatches %0d", checks, failCount);
      if (failCount == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #20000 failCount++;
      printVerdict();
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      #1 rst = 1'b0;
      special_function_register(1'b0, 8'h81, 8'h00);
      `CHK("sp", 8'h07, got);
      `CHK("hit", 1'b1, hit);
      special_function_register(1'b1, 8'h82, 8'h5a);
      special_function_register(1'b1, 8'h83, 8'hc3);
      `CHK("data_pointer", 16'hc35a, dataPointer);
      special_function_register(1'b0, 8'h83, 8'h00);
      `CHK("dph", 8'hc3, got);
      special_function_register(1'b1, 8'h81, 8'hfe);
      core.op(1'b1, 8'h33, got);
      `CHK("sp", 8'hff, stackPointer);
      core.op(1'b1, 8'h44, got);
      `CHK("sp", 8'h00, stackPointer);
      core.op(1'b0, 8'h00, got);
      `CHK("pop", 8'h44, got);
      `CHK("sp", 8'hff, stackPointer);
      core.op(1'b0, 8'h00, got);
      `CHK("pop", 8'h33, got);
      special_function_register(1'b1, 8'h84, 8'h00);
      `CHK("data_pointer", 16'hc35a, dataPointer);
      special_function_register(1'b0, 8'h84, 8'h00);
      `CHK("rsv", 8'h00, got);
      `CHK("hit", 1'b0, hit);
      rst = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 rst = 1'b0;
      `CHK("data_pointer", 16'h0000, dataPointer);
      special_function_register(1'b0, 8'h81, 8'h00);
      `CHK("sp", 8'h07, got);
      printVerdict();
   end
endmodule
